/* shared/data_move_consts.vh */
// Constants for the data-move execution block
`ifndef DATA_MOVE_CONSTS_VH
`define DATA_MOVE_CONSTS_VH

// ----------------------------------------------------------------------
// Operation codes presented on i_op
// ----------------------------------------------------------------------
`define OP_W               3
`define OP_NONE            3'h0
`define OP_REG_MOVE        3'h1
`define OP_IND_LOAD        3'h2
`define OP_BANK_LIT        3'h3
`define OP_LATCH_LIT       3'h4
`define OP_ACC_LIT         3'h5
`define OP_ACC_STORE       3'h6

// ----------------------------------------------------------------------
// Pointer update codes
// ----------------------------------------------------------------------
`define UPD_PRE_INC        2'h0
`define UPD_PRE_DEC        2'h1
`define UPD_POST_INC       2'h2
`define UPD_POST_DEC       2'h3

// ----------------------------------------------------------------------
// Widths, addresses and reset values
// ----------------------------------------------------------------------
`define PTR_W              16
`define OFS_W              6
`define FADDR_W            7
`define BANK_W             5
`define LATCH_W            7
`define PTR_ONE            16'h0001
`define IND_PORT0_ADDR     7'h00
`define IND_PORT1_ADDR     7'h01
`define RST_ACC            8'h00
`define RST_PTR            16'h0000
`define RST_BANK           5'h00
`define RST_LATCH          7'h00

`endif

/* src/pointer_step.v */
// Pointer address and update arithmetic for one indirect access
`include "data_move_consts.vh"

module pointer_step #(
    parameter PW = `PTR_W,
    parameter OW = `OFS_W
) (
    input  wire [PW-1:0] i_ptr,
    input  wire          i_use_offset,
    input  wire [1:0]    i_code,
    input  wire [OW-1:0] i_offset,
    output reg  [PW-1:0] o_addr,
    output reg  [PW-1:0] o_next
);
    wire [PW-1:0] inc_v;
    wire [PW-1:0] dec_v;
    wire [PW-1:0] ofs_v;

    // Natural modulo arithmetic gives the wrap at both ends
    assign inc_v = i_ptr + `PTR_ONE;
    assign dec_v = i_ptr - `PTR_ONE;
    assign ofs_v = i_ptr + {{(PW-OW){i_offset[OW-1]}}, i_offset};

    // Address and write-back selection
    always @* begin
        o_addr = i_ptr;
        o_next = i_ptr;
        if (i_use_offset) begin
            o_addr = ofs_v;
        end else begin
            case (i_code)
                `UPD_PRE_INC: begin
                    o_addr = inc_v;
                    o_next = inc_v;
                end
                `UPD_PRE_DEC: begin
                    o_addr = dec_v;
                    o_next = dec_v;
                end
                `UPD_POST_INC: begin
                    o_next = inc_v;
                end
                default: begin
                    o_next = dec_v;
                end
            endcase
        end
    end
endmodule // pointer_step

/* src/data_move_instruction_exec.v */
// Execution of the data-move instruction group
`include "data_move_consts.vh"

module data_move_instruction_exec #(
    parameter PW = `PTR_W,
    parameter OW = `OFS_W
) (
    input  wire                  i_clk,
    input  wire                  i_sys_rst,
    input  wire                  i_issue,
    input  wire [`OP_W-1:0]      i_op,
    input  wire                  i_dest_self,
    input  wire [`FADDR_W-1:0]   i_faddr,
    input  wire [7:0]            i_literal,
    input  wire                  i_ptr_sel,
    input  wire                  i_use_offset,
    input  wire [1:0]            i_pointer_update_code,
    input  wire [OW-1:0]         i_offset,
    input  wire [7:0]            i_file_rdata,
    input  wire [7:0]            i_mem_rdata,
    input  wire                  i_zero_in,
    output reg  [`FADDR_W-1:0]   o_file_addr,
    output reg                   o_file_we,
    output reg  [7:0]            o_file_wdata,
    output reg  [PW-1:0]         o_mem_addr,
    output reg                   o_mem_we,
    output reg  [7:0]            o_mem_wdata,
    output reg  [7:0]            o_acc,
    output reg                   o_zero,
    output reg  [PW-1:0]         o_ptr0,
    output reg  [PW-1:0]         o_ptr1,
    output reg  [`BANK_W-1:0]    o_bank_select_register,
    output reg  [`LATCH_W-1:0]   o_program_counter_high_latch,
    output reg                   o_done
);
    // ------------------------------------------------------------------
    // Operating contract
    // ------------------------------------------------------------------
    // An operation is taken at the rising edge where i_issue is high and
    // all of its results land on that same edge, so operations may issue
    // back to back with no bubble between them.
    // Limitation: nothing here can stall. The file and the memory must
    // answer within the cycle, for i_faddr and for the address that the
    // caller derives from the pointers; o_mem_addr then reports which
    // memory address was used, so the caller can check its own lookup.
    // Writes leave as one-cycle strobes with address and data beside
    // them. No copy of the file is kept here, so a write followed at once
    // by a read of the same register relies on the file forwarding it.

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // The read data is expected combinationally for i_faddr and for the
    // pointer address that the caller derives; this keeps each operation to one cycle.
    wire [PW-1:0] cur_ptr;
    wire [PW-1:0] ind_addr;
    wire [PW-1:0] ind_next;
    wire          dir_ind0;
    wire          dir_ind1;
    wire          dir_ind;
    wire [PW-1:0] dir_ptr;

    assign cur_ptr  = i_ptr_sel ? o_ptr1 : o_ptr0;
    // Direct operand naming an indirect data port is redirected
    assign dir_ind0 = (i_faddr == `IND_PORT0_ADDR);
    assign dir_ind1 = (i_faddr == `IND_PORT1_ADDR);
    assign dir_ind  = dir_ind0 | dir_ind1;
    assign dir_ptr  = dir_ind1 ? o_ptr1 : o_ptr0;

    // Shared pointer arithmetic
    pointer_step #(
        .PW (PW),
        .OW (OW)
    ) u_step (
        .i_ptr        (cur_ptr),
        .i_use_offset (i_use_offset),
        .i_code       (i_pointer_update_code),
        .i_offset     (i_offset),
        .o_addr       (ind_addr),
        .o_next       (ind_next)
    );

    // Lookup addresses driven combinationally ahead of the result edge
    reg [PW-1:0] rd_addr_c;
    reg          rd_ind_c;
    always @* begin
        rd_ind_c  = 1'b0;
        rd_addr_c = dir_ptr;
        if (i_op == `OP_IND_LOAD) begin
            rd_ind_c  = 1'b1;
            rd_addr_c = ind_addr;
        end else if (dir_ind) begin
            rd_ind_c  = 1'b1;
        end
    end

    wire [7:0] src_val;
    // Caller presents read data for i_faddr (file) or rd_addr_c (memory)
    assign src_val = rd_ind_c ? i_mem_rdata : i_file_rdata;

    // Internal combinational lookup address, registered into o_mem_addr for the caller
    wire [PW-1:0] mem_lookup;
    assign mem_lookup = rd_addr_c;

    // ------------------------------------------------------------------
    // Pointer update strobes
    // ------------------------------------------------------------------
    // Only the indirect load steps a pointer, and only the one that it
    // selects; a direct access through a data port leaves both alone.
    // The strobe is qualified by the issue level, so a stale op code in
    // an idle cycle cannot step a pointer.
    localparam NPTR = 2;

    wire            do_ind;
    wire [NPTR-1:0] ptr_we;

    assign do_ind = i_issue & (i_op == `OP_IND_LOAD);

    // One enable per pointer; the select bit picks the matching index
    genvar g;
    generate
        for (g = 0; g < NPTR; g = g + 1) begin : g_ptr_we
            assign ptr_we[g] = do_ind & (i_ptr_sel ^ (g == 0));
        end
    endgenerate

    // ------------------------------------------------------------------
    // Execute: all state updates land on one edge
    // ------------------------------------------------------------------
    // Flags only change where the operation defines them; the bank,
    // latch and literal paths keep the zero flag as it was.
    // Every output is a flop, so the caller never sees a glitch from
    // the combinational read path; the price is one cycle of latency.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_acc                        <= `RST_ACC;
            o_zero                       <= 1'b0;
            o_ptr0                       <= `RST_PTR;
            o_ptr1                       <= `RST_PTR;
            o_bank_select_register       <= `RST_BANK;
            o_program_counter_high_latch <= `RST_LATCH;
            o_file_addr                  <= {`FADDR_W{1'b0}};
            o_file_we                    <= 1'b0;
            o_file_wdata                 <= 8'h00;
            o_mem_addr                   <= `RST_PTR;
            o_mem_we                     <= 1'b0;
            o_mem_wdata                  <= 8'h00;
            o_done                       <= 1'b0;
        end else begin
            // Strobes fall back to idle unless an operation raises them
            o_file_we  <= 1'b0;
            o_mem_we   <= 1'b0;
            o_done     <= i_issue;
            o_mem_addr <= mem_lookup;
            // The zero flag lives here; the status input is not used
            o_zero     <= i_zero_in ? o_zero : o_zero;
            // Pointer write-back sits outside the op case, so each
            // pointer has one plainly visible enable
            if (ptr_we[0]) begin
                o_ptr0 <= ind_next;
            end
            if (ptr_we[1]) begin
                o_ptr1 <= ind_next;
            end

            if (i_issue) begin
                case (i_op)
                    // Copy to the accumulator or back to the same register
                    `OP_REG_MOVE: begin
                        o_zero <= (src_val == 8'h00);
                        if (i_dest_self) begin
                            if (dir_ind) begin
                                o_mem_addr  <= dir_ptr;
                                o_mem_wdata <= src_val;
                                o_mem_we    <= 1'b1;
                            end else begin
                                o_file_addr  <= i_faddr;
                                o_file_wdata <= src_val;
                                o_file_we    <= 1'b1;
                            end
                        end else begin
                            o_acc <= src_val;
                        end
                    end
                    // Load through a pointer; its step is taken above
                    `OP_IND_LOAD: begin
                        o_acc  <= src_val;
                        o_zero <= (src_val == 8'h00);
                    end
                    // Five-bit literal, flags untouched
                    `OP_BANK_LIT: begin
                        o_bank_select_register <= i_literal[`BANK_W-1:0];
                    end
                    // Seven-bit literal, flags untouched
                    `OP_LATCH_LIT: begin
                        o_program_counter_high_latch <= i_literal[`LATCH_W-1:0];
                    end
                    // Eight-bit literal, flags untouched
                    `OP_ACC_LIT: begin
                        o_acc <= i_literal;
                    end
                    // Accumulator out to a register or through a data port
                    `OP_ACC_STORE: begin
                        if (dir_ind) begin
                            o_mem_addr  <= dir_ptr;
                            o_mem_wdata <= o_acc;
                            o_mem_we    <= 1'b1;
                        end else begin
                            o_file_addr  <= i_faddr;
                            o_file_wdata <= o_acc;
                            o_file_we    <= 1'b1;
                        end
                    end
                    // Unused codes do nothing beyond the done pulse
                    default: begin
                        o_done <= i_issue;
                    end
                endcase
            end
        end
    end
endmodule // data_move_instruction_exec

/* test/data_move_instruction_exec_chk.sv */
// Assertion checker for the data-move execution block
`include "data_move_consts.vh"
module data_move_instruction_exec_chk #(parameter PW = 16, parameter OW = 6) (
    input wire                i_clk, i_sys_rst, i_issue, i_dest_self, i_ptr_sel, i_use_offset,
    input wire [`OP_W-1:0]    i_op,
    input wire [`FADDR_W-1:0] i_faddr, o_file_addr,
    input wire [7:0]          i_literal, i_file_rdata, i_mem_rdata, o_file_wdata, o_acc,
    input wire [1:0]          i_pointer_update_code,
    input wire                o_file_we, o_zero, o_done,
    input wire [PW-1:0]       o_ptr0, o_ptr1,
    input wire [`BANK_W-1:0]  o_bank_select_register,
    input wire [`LATCH_W-1:0] o_program_counter_high_latch
);
    // ------
    // Properties on the core clock
    // ------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Direct ops only; ports 0 and 1 go to memory instead
    wire mv = i_issue && i_op == `OP_REG_MOVE && i_faddr > 7'h01;
    wire st = i_issue && i_op == `OP_ACC_STORE && i_faddr > 7'h01;
    wire ind = i_issue && i_op == `OP_IND_LOAD;
    a_issue_done: assert property (i_issue && i_op inside {[1:6]} |=> o_done)
        else $error("no done after issue");
    a_move_acc: assert property (mv && !i_dest_self |=> o_acc == $past(i_file_rdata)
        && o_zero == (o_acc == 8'h00)) else $error("move to acc wrong");
    a_move_back: assert property (mv && i_dest_self |=> o_file_we && o_file_wdata ==
        $past(i_file_rdata) && o_file_addr == $past(i_faddr) && o_zero == (o_file_wdata == 8'h00))
        else $error("move back wrong");
    a_ind_load: assert property (ind |=> o_acc == $past(i_mem_rdata) && o_zero == !(|o_acc))
        else $error("indirect load wrong");
    a_ptr_step: assert property (ind && !i_ptr_sel && !i_use_offset |=> o_ptr0 ==
        $past(o_ptr0) + ($past(i_pointer_update_code[0]) ? 16'hFFFF : 16'h0001))
        else $error("pointer step wrong");
    a_offset_keep: assert property (ind && i_ptr_sel && i_use_offset |=> $stable(o_ptr1))
        else $error("offset moved pointer");
    a_bank_lit: assert property (i_issue && i_op == `OP_BANK_LIT |=> $stable(o_zero)
        && o_bank_select_register == $past(i_literal[4:0])) else $error("bank load wrong");
    a_latch_lit: assert property (i_issue && i_op == `OP_LATCH_LIT |=> $stable(o_zero)
        && o_program_counter_high_latch == $past(i_literal[6:0]))
        else $error("latch load wrong");
    a_acc_lit: assert property (i_issue && i_op == `OP_ACC_LIT |=> $stable(o_zero)
        && o_acc == $past(i_literal)) else $error("acc literal wrong");
    a_acc_store: assert property (st |=> o_file_we && o_file_wdata == $past(o_acc)
        && $stable(o_zero)) else $error("store wrong");
endmodule // data_move_instruction_exec_chk

bind data_move_instruction_exec data_move_instruction_exec_chk #(.PW(PW), .OW(OW)) i_chk (.*);

/* test/data_move_instruction_exec_test.sv */
// Self-checking testbench for the data-move execution block
`include "data_move_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module data_move_instruction_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Stimulus, memory image and design
    // ------
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_issue = 1'b0, i_dest_self = 1'b0;
    logic        i_ptr_sel = 1'b0, i_use_offset = 1'b0;
    logic [2:0]  i_op = 3'h0;
    logic [6:0]  i_faddr = 7'h00;
    logic [7:0]  i_literal = 8'h00;
    logic [1:0]  i_pointer_update_code = 2'h0;
    logic [5:0]  i_offset = 6'h00;
    logic [15:0] ea = 16'h0000, p0 = 16'h0000; // Address the bench expects, pointer 0 model
    int          fails = 0, samples_checked = 0;
    wire         o_file_we, o_mem_we, o_zero, o_done;
    wire  [7:0]  o_file_wdata, o_mem_wdata, o_acc;
    wire  [15:0] o_mem_addr, o_ptr0, o_ptr1;
    wire  [6:0]  o_file_addr, o_program_counter_high_latch;
    wire  [4:0]  o_bank_select_register;
    // Data depends on both address bytes, so a wrong address shows in the data
    // Zero wherever the two address bytes sum to DFh, as at FFE0h, so an indirect load can also raise the zero flag
    function automatic [7:0] mem(input [15:0] a);
        mem = a[7:0] + a[15:8] + 8'h21;
    endfunction
    wire  [7:0]  i_file_rdata = {1'b0, i_faddr} ^ 8'h5A; // Zero at address 5Ah
    wire  [7:0]  i_mem_rdata = mem(ea);
    data_move_instruction_exec i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_issue(i_issue), .i_op(i_op),
        .i_dest_self(i_dest_self), .i_faddr(i_faddr), .i_literal(i_literal),
        .i_ptr_sel(i_ptr_sel), .i_use_offset(i_use_offset), .i_offset(i_offset),
        .i_pointer_update_code(i_pointer_update_code), .i_zero_in(1'b0),
        .i_file_rdata(i_file_rdata), .i_mem_rdata(i_mem_rdata), .o_acc(o_acc),
        .o_file_addr(o_file_addr), .o_file_we(o_file_we), .o_file_wdata(o_file_wdata),
        .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
        .o_zero(o_zero), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_done(o_done),
        .o_bank_select_register(o_bank_select_register),
        .o_program_counter_high_latch(o_program_counter_high_latch));
    initial forever #12.5 i_clk = ~i_clk;
    // One op for one cycle, judged after the answering edge has settled
    task automatic run(input [2:0] c, input d, input [6:0] f, input [7:0] k, input s,
                       input u, input [1:0] m, input [5:0] o, input [15:0] a);
        @(posedge i_clk);
        i_issue <= 1'b1;
        i_op <= c;
        i_dest_self <= d;
        i_faddr <= f;
        i_literal <= k;
        i_ptr_sel <= s;
        i_use_offset <= u;
        i_pointer_update_code <= m;
        i_offset <= o;
        ea <= a;
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        `CHK("done", 1'b1, o_done)
    endtask
    // Zero flag set by a move must survive literals and store
    task automatic t_direct;
        run(`OP_REG_MOVE, 1'b0, 7'h5A, '0, '0, '0, '0, '0, '0);
        `CHK("move_acc", 9'h100, {o_zero, o_acc})
        run(`OP_ACC_LIT, '0, '0, 8'hFF, '0, '0, '0, '0, '0);
        `CHK("lit_acc", 9'h1FF, {o_zero, o_acc})
        run(`OP_BANK_LIT, '0, '0, 8'hF5, '0, '0, '0, '0, '0);
        `CHK("bank", 6'h35, {o_zero, o_bank_select_register})
        run(`OP_LATCH_LIT, '0, '0, 8'hD3, '0, '0, '0, '0, '0);
        `CHK("latch", 8'hD3, {o_zero, o_program_counter_high_latch})
        run(`OP_ACC_STORE, '0, 7'h7F, '0, '0, '0, '0, '0, '0);
        `CHK("store", 17'h1FFFF, {o_zero, o_file_we, o_file_addr, o_file_wdata})
        run(`OP_REG_MOVE, 1'b1, 7'h10, '0, '0, '0, '0, '0, '0);
        `CHK("move_self", 17'h0904A, {o_zero, o_file_we, o_file_addr, o_file_wdata})
        `CHK("acc_kept", 8'hFF, o_acc)
    endtask
    // All update codes from pointer zero, so both bounds are crossed
    task automatic t_indirect;
        logic [15:0] a;
        logic [1:0]  m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i) ^ 2'h1;
            a = (m == `UPD_PRE_INC) ? p0 + 16'h0001 : (m == `UPD_PRE_DEC) ? p0 - 16'h0001 : p0;
            p0 = m[0] ? p0 - 16'h0001 : p0 + 16'h0001;
            run(`OP_IND_LOAD, '0, '0, '0, 1'b0, 1'b0, m, '0, a);
            `CHK("ind_acc", {mem(a) == 8'h00, mem(a)}, {o_zero, o_acc})
            `CHK("ind_addr", a, o_mem_addr)
            `CHK("ptr0", p0, o_ptr0)
        end
        run(`OP_IND_LOAD, '0, '0, '0, 1'b1, 1'b1, '0, 6'h20, 16'hFFE0);
        `CHK("ofs_lo", {mem(16'hFFE0), 16'h0000}, {o_acc, o_ptr1})
        `CHK("ofs_lo_ea", {1'b1, 16'hFFE0}, {o_zero, o_mem_addr})
        run(`OP_IND_LOAD, '0, '0, '0, 1'b1, 1'b1, '0, 6'h1F, 16'h001F);
        `CHK("ofs_hi", {mem(16'h001F), 16'h0000}, {o_acc, o_ptr1})
        `CHK("ofs_hi_ea", {1'b0, 16'h001F}, {o_zero, o_mem_addr})
    endtask
    // Direct access to ports 0 and 1 must land at the pointers' addresses
    task automatic t_ports;
        run(`OP_IND_LOAD, '0, '0, '0, 1'b1, 1'b0, `UPD_POST_INC, '0, 16'h0000);
        `CHK("ptr1", 16'h0001, o_ptr1)
        run(`OP_REG_MOVE, 1'b0, `IND_PORT1_ADDR, '0, '0, '0, '0, '0, 16'h0001);
        `CHK("port_acc", {16'h0001, mem(16'h0001)}, {o_mem_addr, o_acc})
        run(`OP_ACC_STORE, '0, `IND_PORT0_ADDR, '0, '0, '0, '0, '0, 16'h0000);
        `CHK("port_we", 2'b10, {o_mem_we, o_file_we})
        `CHK("port_wr", {16'h0000, mem(16'h0001)}, {o_mem_addr, o_mem_wdata})
        // An unused op code must change nothing, not even the selected pointer
        run(3'h7, 1'b1, 7'h10, 8'h00, 1'b1, 1'b0, `UPD_POST_INC, '0, 16'h0000);
        `CHK("refused", {mem(16'h0001), 2'b00}, {o_acc, o_mem_we, o_file_we})
        `CHK("refused_ptr", 16'h0001, o_ptr1)
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Hang guard; the run needs under a hundred cycles
    initial begin
        repeat (2000) @(posedge i_clk);
        fails++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK("reset", 47'h0, {o_acc, o_zero, o_ptr0, o_ptr1, o_bank_select_register, o_done})
        t_direct();
        t_indirect();
        t_ports();
        summarize();
    end
endmodule // data_move_instruction_exec_test
